/* verilog/shift_rotate_mask_pkg.sv */
// constants and types shared by the shift, rotate and mask unit
package shift_rotate_mask_pkg;

    // ****************************************************************
    // operand widths
    // ****************************************************************
    localparam int WORD_W = 32;
    localparam int DWORD_W = 64;
    localparam int WORD_AMT_W = 5;
    localparam int DWORD_AMT_W = 7;
    localparam int CR_FIELD_W = 4;

    // ****************************************************************
    // field positions, counted from the least significant bit
    // ****************************************************************
    // big-endian bits 27-31 of the shift-amount word
    localparam int WORD_AMT_LSB = 0;
    // big-endian bit 26 of the shift-amount word
    localparam int MASK_OFF_POS = 5;
    // low-order seven bits of the shift-amount register
    localparam int DWORD_AMT_LSB = 0;
    // big-endian bit 0, the sign of each operand width
    localparam int WORD_SIGN_POS = 31;
    localparam int DWORD_SIGN_POS = 63;
    // condition field zero layout
    localparam int CR_LT_POS = 3;
    localparam int CR_GT_POS = 2;
    localparam int CR_EQ_POS = 1;
    localparam int CR_SO_POS = 0;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [WORD_W-1:0] EXTRA_QUOTIENT_RESET = 32'h0000_0000;
    localparam logic [DWORD_W-1:0] TARGET_RESET = 64'h0000_0000_0000_0000;
    localparam logic [CR_FIELD_W-1:0] CR_FIELD_RESET = 4'h0;
    localparam logic SHIFT_OUT_FLAG_RESET = 1'b0;

    // ****************************************************************
    // latency: issue edge to the edge where results stand
    // ****************************************************************
    localparam int RESULT_LATENCY_CYCLES = 1;

    // ****************************************************************
    // operation selector
    // ****************************************************************
    typedef enum logic [1:0] {
        OP_SHIFT_LEFT_SAVE = 2'h0,
        OP_SHIFT_LEFT_WORD = 2'h1,
        OP_SHIFT_LEFT_LEGACY = 2'h2,
        OP_SHIFT_RIGHT_ALG_DW = 2'h3
    } shift_op_t;

endpackage : shift_rotate_mask_pkg

/* verilog/shift_rotate_mask_unit.sv */
// shift, rotate and mask datapath with extra quotient register and flags
//
// Function
// RULE_01 - save-shift rotates source left by low five bits, full word saved
// RULE_02 - save-shift mask: 32-N ones then N zeros, all zeros if bit 26
// RULE_03 - save-shift target gets rotated word AND mask
// RULE_04 - left shifts never touch the fixed-point exception register
// RULE_05 - save-shift with record bit updates condition field zero, else not
// RULE_06 - word shift rotates source left by low five bits, writes AND mask
// RULE_07 - word shift mask: 32-N ones then N zeros, all zeros if bit 26
// RULE_08 - both word shift spellings identical; record bit updates field zero
// RULE_09 - double shift amount uses only low seven bits
// RULE_10 - double shift drops bits past 63, fills with sign bit
// RULE_11 - double shift carry set only if negative and ones shifted out
// RULE_12 - double shift by zero copies source and clears carry
// RULE_13 - double shift by 64-127 gives all sign bits, carry equals sign
// RULE_14 - double shift with record bit updates condition field zero
// RULE_15 - double shift carry computed alike in every operating mode
// RULE_16 - double shift illegal on 32-bit implementations, raises error
// RULE_17 - word shift leaves extra quotient register unchanged
// RULE_18 - field zero: signed compare with zero, overflow copied in
`timescale 1ns/1ps

module shift_rotate_mask_unit #(
    parameter bit IMPL_64 = 1'b1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic issue_valid_in,
    input wire shift_rotate_mask_pkg::shift_op_t op_in,
    input wire logic record_bit_in,
    input wire logic [shift_rotate_mask_pkg::DWORD_W-1:0] source_gpr_in,
    input wire logic [shift_rotate_mask_pkg::DWORD_W-1:0]
        shift_amount_gpr_in,
    input wire logic summary_overflow_in,
    input wire logic extra_quotient_load_in,
    input wire logic [shift_rotate_mask_pkg::WORD_W-1:0]
        extra_quotient_data_in,
    output logic result_valid_out,
    output logic target_write_out,
    output logic [shift_rotate_mask_pkg::DWORD_W-1:0] target_gpr_out,
    output logic [shift_rotate_mask_pkg::WORD_W-1:0]
        extra_quotient_register_out,
    output logic shift_out_flag_out,
    output logic shift_out_flag_write_out,
    output logic [shift_rotate_mask_pkg::CR_FIELD_W-1:0]
        condition_field_zero_out,
    output logic condition_field_zero_write_out,
    output logic illegal_instruction_out
);
    import shift_rotate_mask_pkg::*;

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // rotate a word left; the doubled word keeps n = 0 clean
    function automatic logic [WORD_W-1:0] rotate_word_left(
        input logic [WORD_W-1:0] value,
        input logic [WORD_AMT_W-1:0] amount
    );
        logic [2*WORD_W-1:0] doubled;
        doubled = {value, value} << amount;
        return doubled[2*WORD_W-1:WORD_W];
    endfunction : rotate_word_left

    // 32-N ones then N zeros, or all zeros when the off bit is set
    function automatic logic [WORD_W-1:0] left_mask(
        input logic [WORD_AMT_W-1:0] amount,
        input logic mask_off
    );
        logic [WORD_W-1:0] ones;
        ones = {WORD_W{1'b1}};
        if (mask_off) begin
            return {WORD_W{1'b0}};
        end
        return ones << amount;
    endfunction : left_mask

    // signed compare against zero plus the copied summary overflow
    function automatic logic [CR_FIELD_W-1:0] compare_field(
        input logic sign,
        input logic is_zero,
        input logic overflow
    );
        logic [CR_FIELD_W-1:0] field;
        field = CR_FIELD_RESET;
        field[CR_LT_POS] = sign;
        field[CR_GT_POS] = ~sign & ~is_zero;
        field[CR_EQ_POS] = is_zero;
        field[CR_SO_POS] = overflow;
        return field;
    endfunction : compare_field

    // ****************************************************************
    // operation decode
    // ****************************************************************
    wire logic op_is_save;
    wire logic op_is_word;
    wire logic op_is_dword;
    wire logic dword_illegal;
    wire logic issue_legal;
    wire logic issue_illegal;

    assign op_is_save = (op_in == OP_SHIFT_LEFT_SAVE);
    // both spellings of the word shift share one path
    assign op_is_word = (op_in == OP_SHIFT_LEFT_WORD) ||
        (op_in == OP_SHIFT_LEFT_LEGACY); // RULE_08
    assign op_is_dword = (op_in == OP_SHIFT_RIGHT_ALG_DW);
    assign dword_illegal = op_is_dword && !IMPL_64; // RULE_16
    assign issue_legal = issue_valid_in && !dword_illegal;
    assign issue_illegal = issue_valid_in && dword_illegal; // RULE_16

    // ****************************************************************
    // word shift amount and mask control
    // ****************************************************************
    wire logic [WORD_W-1:0] source_word;
    wire logic [WORD_AMT_W-1:0] word_amount;
    wire logic word_mask_off;

    assign source_word = source_gpr_in[WORD_W-1:0];
    assign word_amount =
        shift_amount_gpr_in[WORD_AMT_LSB +: WORD_AMT_W]; // RULE_01 RULE_06
    assign word_mask_off =
        shift_amount_gpr_in[MASK_OFF_POS]; // RULE_02 RULE_07

    // ****************************************************************
    // left rotate and mask, shared by the save and word shifts
    // ****************************************************************
    wire logic [WORD_W-1:0] rotated_word;
    wire logic [WORD_W-1:0] word_mask;
    wire logic [WORD_W-1:0] masked_word;
    wire logic [DWORD_W-1:0] word_result;

    assign rotated_word =
        rotate_word_left(source_word, word_amount); // RULE_01 RULE_06
    assign word_mask =
        left_mask(word_amount, word_mask_off); // RULE_02 RULE_07
    assign masked_word = rotated_word & word_mask; // RULE_03 RULE_06
    // the upper half of the target is cleared for word results
    assign word_result = {{(DWORD_W-WORD_W){1'b0}}, masked_word};

    // ****************************************************************
    // algebraic right shift of the double word
    // ****************************************************************
    wire logic [DWORD_AMT_W-1:0] dword_amount;
    wire logic dword_sign;
    wire logic dword_full_shift;
    wire logic [DWORD_W-1:0] dword_shifted;
    wire logic [DWORD_W-1:0] dword_lost_mask;
    wire logic dword_ones_lost;
    wire logic [DWORD_W-1:0] dword_result;
    wire logic dword_carry;

    // higher bits of the amount register are never looked at
    assign dword_amount =
        shift_amount_gpr_in[DWORD_AMT_LSB +: DWORD_AMT_W]; // RULE_09
    assign dword_sign = source_gpr_in[DWORD_SIGN_POS];
    assign dword_full_shift = dword_amount[DWORD_AMT_W-1]; // RULE_13
    // arithmetic shift drops low bits and replicates the sign
    assign dword_shifted =
        DWORD_W'($signed(source_gpr_in) >>>
        dword_amount[DWORD_AMT_W-2:0]); // RULE_10
    // ones below the shift amount are the bits that fall off
    assign dword_lost_mask =
        ~({DWORD_W{1'b1}} << dword_amount[DWORD_AMT_W-2:0]);
    // an amount of zero yields an empty lost mask and a clear carry
    assign dword_ones_lost =
        |(source_gpr_in & dword_lost_mask); // RULE_12
    assign dword_result = dword_full_shift ?
        {DWORD_W{dword_sign}} : dword_shifted; // RULE_13 RULE_12
    // no mode input reaches the carry path
    assign dword_carry = dword_full_shift ? dword_sign :
        (dword_sign & dword_ones_lost); // RULE_11 RULE_13 RULE_15

    // ****************************************************************
    // result selection and condition field
    // ****************************************************************
    wire logic [DWORD_W-1:0] selected_result;
    wire logic result_sign;
    wire logic result_zero;
    wire logic [CR_FIELD_W-1:0] new_field;

    assign selected_result = op_is_dword ? dword_result : word_result;
    // word results compare as 32-bit signed values
    assign result_sign = op_is_dword ? dword_result[DWORD_SIGN_POS] :
        masked_word[WORD_SIGN_POS]; // RULE_18
    assign result_zero = op_is_dword ? (dword_result == TARGET_RESET) :
        (masked_word == EXTRA_QUOTIENT_RESET); // RULE_18
    assign new_field = compare_field(result_sign, result_zero,
        summary_overflow_in); // RULE_18

    // ****************************************************************
    // next values of the architected state and strobes
    // ****************************************************************
    wire logic next_result_valid;
    wire logic next_target_write;
    wire logic [DWORD_W-1:0] next_target;
    wire logic next_quotient_write;
    wire logic [WORD_W-1:0] next_quotient;
    wire logic next_carry_write;
    wire logic next_carry;
    wire logic next_field_write;
    wire logic [CR_FIELD_W-1:0] next_field;
    wire logic next_illegal;

    assign next_result_valid = issue_valid_in;
    assign next_target_write = issue_legal;
    assign next_target = issue_legal ? selected_result : target_gpr_out;

    // only the save shift writes the extra quotient register;
    // a save shift wins over a same-cycle software load
    assign next_quotient_write =
        issue_legal && op_is_save; // RULE_01 RULE_17
    assign next_quotient = next_quotient_write ? rotated_word :
        (extra_quotient_load_in ? extra_quotient_data_in :
        extra_quotient_register_out); // RULE_17

    // left shifts leave the exception register alone
    assign next_carry_write =
        issue_legal && op_is_dword; // RULE_04 RULE_11
    assign next_carry = next_carry_write ? dword_carry :
        shift_out_flag_out; // RULE_04

    // the field only changes when the record bit asks for it
    assign next_field_write = issue_legal && record_bit_in &&
        (op_is_save || op_is_word || op_is_dword); // RULE_05 RULE_08 RULE_14
    assign next_field = next_field_write ? new_field :
        condition_field_zero_out; // RULE_05
    assign next_illegal = issue_illegal; // RULE_16

    // ****************************************************************
    // strobe registers
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            result_valid_out <= 1'b0;
            target_write_out <= 1'b0;
            shift_out_flag_write_out <= 1'b0;
            condition_field_zero_write_out <= 1'b0;
            illegal_instruction_out <= 1'b0;
        end else begin
            result_valid_out <= next_result_valid;
            target_write_out <= next_target_write;
            shift_out_flag_write_out <= next_carry_write;
            condition_field_zero_write_out <= next_field_write;
            illegal_instruction_out <= next_illegal;
        end
    end

    // ****************************************************************
    // result register
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            target_gpr_out <= TARGET_RESET;
        end else begin
            target_gpr_out <= next_target;
        end
    end

    // ****************************************************************
    // extra quotient register
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            extra_quotient_register_out <= EXTRA_QUOTIENT_RESET;
        end else begin
            extra_quotient_register_out <= next_quotient;
        end
    end

    // ****************************************************************
    // carry and condition field registers
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            shift_out_flag_out <= SHIFT_OUT_FLAG_RESET;
            condition_field_zero_out <= CR_FIELD_RESET;
        end else begin
            shift_out_flag_out <= next_carry;
            condition_field_zero_out <= next_field;
        end
    end

endmodule : shift_rotate_mask_unit

/* testbench/shift_rotate_mask_chk.sv */
// assertion checker for the shift, rotate and mask unit
`timescale 1ns/1ps
module shift_rotate_mask_chk #(
    parameter bit IMPL_64 = 1'b1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic issue_valid_in,
    input wire shift_rotate_mask_pkg::shift_op_t op_in,
    input wire logic record_bit_in,
    input wire logic [63:0] source_gpr_in,
    input wire logic [63:0] shift_amount_gpr_in,
    input wire logic summary_overflow_in,
    input wire logic extra_quotient_load_in,
    input wire logic target_write_out,
    input wire logic [63:0] target_gpr_out,
    input wire logic [31:0] extra_quotient_register_out,
    input wire logic shift_out_flag_out,
    input wire logic shift_out_flag_write_out,
    input wire logic [3:0] condition_field_zero_out,
    input wire logic condition_field_zero_write_out,
    input wire logic illegal_instruction_out
);
    import shift_rotate_mask_pkg::*;
    // ****************************************************************
    // reference helpers
    // ****************************************************************
    function automatic logic [31:0] rotl(logic [31:0] v, logic [4:0] n);
        logic [63:0] d;
        d = {v, v} << n;
        return d[63:32];
    endfunction : rotl
    function automatic logic [31:0] word_res(logic [31:0] v, logic [5:0] a);
        return a[5] ? 32'h0 : rotl(v, a[4:0]) & (32'hffff_ffff << a[4:0]);
    endfunction : word_res
    function automatic logic [3:0] cr(logic [63:0] v, logic w, logic so);
        logic lt;
        logic eq;
        lt = w ? v[63] : v[31];
        eq = w ? v == 64'h0 : v[31:0] == 32'h0;
        return {lt, !lt && !eq, eq, so};
    endfunction : cr
    wire logic is_dw = op_in == OP_SHIFT_RIGHT_ALG_DW;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence s_left;
        issue_valid_in && !is_dw;
    endsequence
    sequence s_dw;
        issue_valid_in && is_dw;
    endsequence
    a_save_rotate:
        assert property ((s_left and (op_in == OP_SHIFT_LEFT_SAVE)) |=>
            extra_quotient_register_out == rotl($past(source_gpr_in[31:0]),
            $past(shift_amount_gpr_in[4:0])))
        else $error("save rotate wrong");
    a_word_result:
        assert property (s_left |=> target_write_out && target_gpr_out ==
            {32'h0, word_res($past(source_gpr_in[31:0]),
            $past(shift_amount_gpr_in[5:0]))})
        else $error("word result wrong");
    a_word_quot_hold:
        assert property ((s_left and (op_in != OP_SHIFT_LEFT_SAVE &&
            !extra_quotient_load_in)) |=>
            $stable(extra_quotient_register_out))
        else $error("quotient changed");
    a_left_no_carry:
        assert property (s_left |=> !shift_out_flag_write_out &&
            $stable(shift_out_flag_out))
        else $error("left shift touched carry");
    a_field_update:
        assert property (issue_valid_in && record_bit_in &&
            (!is_dw || IMPL_64) |=> condition_field_zero_write_out &&
            condition_field_zero_out == cr(target_gpr_out, $past(is_dw),
            $past(summary_overflow_in)))
        else $error("field update wrong");
    a_field_hold:
        assert property (issue_valid_in && !record_bit_in |=>
            !condition_field_zero_write_out &&
            $stable(condition_field_zero_out))
        else $error("field changed");
    a_dw_result:
        assert property ((s_dw and (IMPL_64 == 1'b1)) |=> target_gpr_out ==
            64'($signed($past(source_gpr_in)) >>>
            $past(shift_amount_gpr_in[6:0])))
        else $error("double shift result wrong");
    a_dw_carry:
        assert property ((s_dw and (IMPL_64 == 1'b1)) |=>
            shift_out_flag_write_out &&
            shift_out_flag_out == ($past(source_gpr_in[63]) &&
            |($past(source_gpr_in) & ~(64'hffff_ffff_ffff_ffff <<
            $past(shift_amount_gpr_in[6:0])))))
        else $error("double shift carry wrong");
    a_dw_illegal:
        assert property ((s_dw and (IMPL_64 == 1'b0)) |=>
            illegal_instruction_out &&
            !target_write_out && !shift_out_flag_write_out)
        else $error("illegal double shift not refused");
endmodule : shift_rotate_mask_chk
bind shift_rotate_mask_unit shift_rotate_mask_chk #(.IMPL_64(IMPL_64)) u_chk (
    .clk_in(clk_in), .reset_in(reset_in), .issue_valid_in(issue_valid_in),
    .op_in(op_in), .record_bit_in(record_bit_in),
    .source_gpr_in(source_gpr_in), .shift_amount_gpr_in(shift_amount_gpr_in),
    .summary_overflow_in(summary_overflow_in),
    .extra_quotient_load_in(extra_quotient_load_in),
    .target_write_out(target_write_out), .target_gpr_out(target_gpr_out),
    .extra_quotient_register_out(extra_quotient_register_out),
    .shift_out_flag_out(shift_out_flag_out),
    .shift_out_flag_write_out(shift_out_flag_write_out),
    .condition_field_zero_out(condition_field_zero_out),
    .condition_field_zero_write_out(condition_field_zero_write_out),
    .illegal_instruction_out(illegal_instruction_out));

/* testbench/gpr_issue_model.sv */
// decoder and register file model that issues operations to the unit
`timescale 1ns/1ps
module gpr_issue_model (
    input wire logic clk_in,
    output logic issue_valid_out,
    output shift_rotate_mask_pkg::shift_op_t op_out,
    output logic record_bit_out,
    output logic [63:0] source_gpr_out,
    output logic [63:0] shift_amount_gpr_out,
    output logic summary_overflow_out,
    output logic quotient_load_out,
    output logic [31:0] quotient_data_out
);
    import shift_rotate_mask_pkg::*;
    // ****************************************************************
    // issue tasks; operand lines show inverted data once released
    // ****************************************************************
    initial begin
        {issue_valid_out, record_bit_out, summary_overflow_out} = 3'h0;
        {source_gpr_out, shift_amount_gpr_out} = 128'h0;
        {quotient_load_out, quotient_data_out} = 33'h0;
        op_out = OP_SHIFT_LEFT_SAVE;
    end
    task automatic issue_op(input shift_op_t op, input logic rec,
        input logic [63:0] src, input logic [63:0] amt, input logic so);
        @(posedge clk_in);
        issue_valid_out <= 1'b1;
        op_out <= op;
        record_bit_out <= rec;
        source_gpr_out <= src;
        shift_amount_gpr_out <= amt;
        summary_overflow_out <= so;
        @(posedge clk_in);
        issue_valid_out <= 1'b0;
        source_gpr_out <= ~src;
        shift_amount_gpr_out <= ~amt;
    endtask : issue_op
    task automatic load_quotient(input logic [31:0] d);
        @(posedge clk_in);
        quotient_load_out <= 1'b1;
        quotient_data_out <= d;
        @(posedge clk_in);
        quotient_load_out <= 1'b0;
        quotient_data_out <= ~d;
    endtask : load_quotient
endmodule : gpr_issue_model

/* testbench/tb_top.sv */
// self-checking bench for the shift, rotate and mask unit
`timescale 1ns/1ps
module tb_top;
    import shift_rotate_mask_pkg::*;
    logic clk_in, reset_in, issue_valid, rec, so, qload, res_valid;
    logic target_write, carry, carry_write, field_write, illegal;
    logic illegal_32, write_32;
    shift_op_t op;
    logic [63:0] src, amt, target;
    logic [31:0] qdata, quot;
    logic [3:0] field;
    int bad_count = 0;
    int n_checks = 0;
    localparam logic [63:0] s_neg = 64'h8000_0000_0000_0001;
    logic [63:0] dw_src [7] = '{s_neg, s_neg, 64'h7000_0000_0000_0001,
        64'h7000_0000_0000_0001, s_neg, 64'h8000_0000_0000_0000, s_neg};
    logic [63:0] dw_amt [7] = '{64'h0, 64'h1, 64'h1, 64'h7f, 64'h40,
        64'h3f, 64'hffff_ffff_ffff_ff81};
    logic [63:0] dw_exp [7] = '{s_neg, 64'hc000_0000_0000_0000,
        64'h3800_0000_0000_0000, 64'h0, 64'hffff_ffff_ffff_ffff,
        64'hffff_ffff_ffff_ffff, 64'hc000_0000_0000_0000};
    logic [6:0] dw_carry = 7'b1010010;
    // ****************************************************************
    // clock, partner and units
    // ****************************************************************
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    gpr_issue_model u_gpr_issue_model (.clk_in(clk_in),
        .issue_valid_out(issue_valid), .op_out(op), .record_bit_out(rec),
        .source_gpr_out(src), .shift_amount_gpr_out(amt),
        .summary_overflow_out(so), .quotient_load_out(qload),
        .quotient_data_out(qdata));
    shift_rotate_mask_unit u_shift_rotate_mask_unit (.clk_in(clk_in),
        .reset_in(reset_in), .issue_valid_in(issue_valid), .op_in(op),
        .record_bit_in(rec), .source_gpr_in(src), .shift_amount_gpr_in(amt),
        .summary_overflow_in(so), .extra_quotient_load_in(qload),
        .extra_quotient_data_in(qdata), .result_valid_out(res_valid),
        .target_write_out(target_write), .target_gpr_out(target),
        .extra_quotient_register_out(quot), .shift_out_flag_out(carry),
        .shift_out_flag_write_out(carry_write),
        .condition_field_zero_out(field),
        .condition_field_zero_write_out(field_write),
        .illegal_instruction_out(illegal));
    shift_rotate_mask_unit #(.IMPL_64(1'b0)) u_shift_rotate_mask_unit_32 (
        .clk_in(clk_in), .reset_in(reset_in), .issue_valid_in(issue_valid),
        .op_in(op), .record_bit_in(rec), .source_gpr_in(src),
        .shift_amount_gpr_in(amt), .summary_overflow_in(so),
        .extra_quotient_load_in(qload), .extra_quotient_data_in(qdata),
        .result_valid_out(), .target_write_out(write_32),
        .target_gpr_out(), .extra_quotient_register_out(),
        .shift_out_flag_out(), .shift_out_flag_write_out(),
        .condition_field_zero_out(), .condition_field_zero_write_out(),
        .illegal_instruction_out(illegal_32));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string name, input logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic run(input shift_op_t o, input logic r,
        input logic [63:0] s, input logic [63:0] a, input logic v);
        u_gpr_issue_model.issue_op(o, r, s, a, v);
        #1;
    endtask : run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        #4000;
        bad_count++;
        wrap_up();
    end
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        reset_in = 1'b1;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        #1;
        check("reset target", target, 64'h0);
        check("reset state", {quot, field, carry, res_valid, target_write,
            field_write, illegal}, 64'h0);
        run(OP_SHIFT_LEFT_SAVE, 1'b1, 64'h8004_3000, 64'h4, 1'b0);
        check("save target", target, 64'h0043_0000);
        check("save quotient", quot, 64'h0043_0008);
        check("save valid", {res_valid, target_write, carry_write},
            64'h6);
        check("save field", {field_write, field}, 64'h14);
        run(OP_SHIFT_LEFT_SAVE, 1'b0, 64'h9000_3000, 64'h24, 1'b0);
        check("masked target", target, 64'h0);
        check("masked quotient", quot, 64'h0003_0009);
        check("no record", {field_write, field}, 64'h4);
        for (int i = 0; i < 7; i++) begin
            run(OP_SHIFT_RIGHT_ALG_DW, 1'b1, dw_src[i], dw_amt[i], 1'b0);
            check("dw target", target, dw_exp[i]);
            check("dw carry", carry, dw_carry[i]);
            check("dw field", field, {dw_exp[i][63], !dw_exp[i][63] &&
                dw_exp[i] != 64'h0, dw_exp[i] == 64'h0, 1'b0});
            check("refused", {illegal_32, write_32, illegal}, 64'h4);
        end
        for (int i = 0; i < 2; i++) begin
            run(i ? OP_SHIFT_LEFT_LEGACY : OP_SHIFT_LEFT_WORD, 1'b1,
                64'hb004_3000, 64'h5, i[0]);
            check("word target", target, 64'h0086_0000);
            check("word field", field, {3'h2, i[0]});
            check("word quotient", quot, 64'h0003_0009);
            check("word carry", {carry_write, carry}, 64'h1);
            run(i ? OP_SHIFT_LEFT_LEGACY : OP_SHIFT_LEFT_WORD, 1'b1,
                64'hffff_ffff, 64'h2f, 1'b1);
            check("word zero", target, 64'h0);
            check("zero field", field, 64'h3);
        end
        u_gpr_issue_model.load_quotient(32'h1234_5678);
        #1;
        check("quotient load", quot, 64'h1234_5678);
        wrap_up();
    end
endmodule : tb_top
